// ==== apt_timer.sv ====
// Advanced PWM timer: counter, four channels, three dead-time pairs,
// break logic and an APB slave. Assumes all inputs are synchronous
// to REF_CLK and the APB master follows the standard handshake.
`timescale 1ns/1ps
`include "apt_defines.svh"

module apt_timer #(
	parameter int CNT_W = 16
) (
	input  wire logic        REF_CLK,       // 50 MHz clock
	input  wire logic        RSTN,          // Synchronous reset, low
	input  wire logic        PSEL,          // APB select
	input  wire logic        PENABLE,       // APB access phase
	input  wire logic        PWRITE,        // APB direction
	input  wire logic [7:0]  PADDR,         // APB byte address
	input  wire logic [31:0] PWDATA,        // APB write data
	output logic      [31:0] PRDATA,        // APB read data
	output logic             PREADY,        // APB ready
	output logic             PSLVERR,       // APB error
	input  wire logic [3:0]  CH_IN,         // Capture inputs
	input  wire logic        DBG_HALT,      // Processor halted
	input  wire logic        TRG_IN,        // Trigger from other timers
	output logic             TRG_OUT,       // Update pulse to others
	input  wire logic        BRK_PIN,       // External break
	input  wire logic        BRK_COMP,      // Comparator break
	input  wire logic        BRK_CLKFAIL,   // Clock security monitor
	input  wire logic        BRK_HARDFAULT, // Processor hard fault
	input  wire logic        BRK_PARITY,    // Memory parity error
	input  wire logic        BRK_ECC,       // Flash ECC error
	input  wire logic        BRK_SUPPLY,    // Supply voltage detector
	output logic      [3:0]  OC,            // Channel main outputs
	output logic      [2:0]  OCN            // Complementary outputs
);

	if (CNT_W < 2 || CNT_W > 16) begin : g_chk
		$error("CNT_W must lie between 2 and 16");
	end

	typedef struct packed {
		logic [CNT_W-1:0]      cnt;
		logic [15:0]           psc_cnt;
		logic                  down;
		logic [15:0]           ctrl;
		logic [15:0]           psc;
		logic [CNT_W-1:0]      arr;
		logic [7:0]            dtg;
		logic [7:0]            chmode;
		logic [6:0]            pol;
		logic [3:0][CNT_W-1:0] ccr;
		logic [5:0]            sts;
		logic [3:0]            ref_o;
		logic [2:0][7:0]       dt;
		logic [3:0]            ch_d;
		logic                  trg_d;
		logic                  trg;
		logic [3:0]            oc;
		logic [2:0]            ocn;
		logic [31:0]           rdata;
	} apt_state_s;

	apt_state_s st_r;
	apt_state_s st_nxt;

	function automatic logic is_reg(input logic [7:0] a, input logic [7:0] o);
		is_reg = (a == o);
	endfunction : is_reg

	function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
		widen = 32'(v);
	endfunction : widen

	logic [6:0]            brk_src;
	logic                  brk_now;
	logic                  frz;
	logic                  tick;
	logic                  upd;
	logic                  wr;
	logic                  hit;
	logic [3:0]            rise;
	logic                  off;
	logic [3:0]            ref_nxt;
	logic [5:0]            sts_set;
	logic [7:0]            a;
	apt_pkg::apt_chmode_e  m;

	always_comb begin
		st_nxt  = st_r;
		a       = PADDR;
		m       = apt_pkg::APT_CAPTURE;
		ref_nxt = st_r.ref_o;
		upd     = 1'b0;
		sts_set = 6'h00;
		// [RQ9] [RQ10] Break source gating
		brk_src = {BRK_SUPPLY, BRK_ECC, BRK_PARITY, BRK_HARDFAULT,
			BRK_CLKFAIL, BRK_COMP, BRK_PIN};
		brk_now = |(brk_src & st_r.ctrl[`APT_CTRL_BRK_LO +: 7]);
		// [RQ7] Debug freeze
		frz  = DBG_HALT & st_r.ctrl[`APT_CTRL_DBGFRZ];
		rise = CH_IN & ~st_r.ch_d;
		st_nxt.ch_d  = CH_IN;
		st_nxt.trg_d = TRG_IN;

		// [RQ2] Prescaler divides by psc plus one
		tick = 1'b0;
		if (st_r.ctrl[`APT_CTRL_EN] && !frz) begin
			if (st_r.psc_cnt >= st_r.psc) begin
				st_nxt.psc_cnt = 16'h0000;
				tick = 1'b1;
			end else begin
				st_nxt.psc_cnt = st_r.psc_cnt + 16'h0001;
			end
		end

		// [RQ1] Up, down and centre counting
		if (tick) begin
			if (st_r.ctrl[`APT_CTRL_CENTER]) begin
				if (!st_r.down) begin
					if (st_r.cnt >= st_r.arr) begin
						st_nxt.down = 1'b1;
						st_nxt.cnt  = st_r.arr - CNT_W'(1);
					end else begin
						st_nxt.cnt = st_r.cnt + CNT_W'(1);
					end
				end else if (st_r.cnt == '0) begin
					st_nxt.down = 1'b0;
					st_nxt.cnt  = CNT_W'(1);
					upd = 1'b1;
				end else begin
					st_nxt.cnt = st_r.cnt - CNT_W'(1);
				end
			end else if (st_r.ctrl[`APT_CTRL_DOWN]) begin
				st_nxt.down = 1'b1;
				if (st_r.cnt == '0) begin
					st_nxt.cnt = st_r.arr;
					upd = 1'b1;
				end else begin
					st_nxt.cnt = st_r.cnt - CNT_W'(1);
				end
			end else begin
				st_nxt.down = 1'b0;
				if (st_r.cnt >= st_r.arr) begin
					st_nxt.cnt = '0;
					upd = 1'b1;
				end else begin
					st_nxt.cnt = st_r.cnt + CNT_W'(1);
				end
			end
		end

		// [RQ8] Trigger input resets or starts
		if (TRG_IN && !st_r.trg_d) begin
			if (st_r.ctrl[`APT_CTRL_TRGRST]) begin
				st_nxt.cnt     = '0;
				st_nxt.psc_cnt = 16'h0000;
			end
			if (st_r.ctrl[`APT_CTRL_TRGGO])
				st_nxt.ctrl[`APT_CTRL_EN] = 1'b1;
		end
		// [RQ8] Update pulse out
		st_nxt.trg = upd;

		// [RQ3] Per-channel mode
		for (int i = 0; i < 4; i++) begin
			m = apt_pkg::apt_chmode_e'(st_r.chmode[2*i +: 2]);
			case (m)
			apt_pkg::APT_CAPTURE: begin
				ref_nxt[i] = 1'b0;
				if (rise[i] && !frz) begin
					st_nxt.ccr[i] = st_r.cnt;
					sts_set[i]    = 1'b1;
				end
			end
			apt_pkg::APT_COMPARE: begin
				if (tick && st_r.cnt == st_r.ccr[i]) begin
					ref_nxt[i]    = ~st_r.ref_o[i];
					sts_set[i]    = 1'b1;
				end
			end
			// [RQ4] Duty from zero to full
			apt_pkg::APT_PWM,
			apt_pkg::APT_ONEPULSE: begin
				ref_nxt[i] = st_r.cnt < st_r.ccr[i];
			end
			default: ref_nxt[i] = 1'b0;
			endcase
		end
		st_nxt.ref_o = ref_nxt;

		// One-pulse (OPM set or channel 0 in one-pulse mode): the counter stops at its first update
		if (upd && (st_r.ctrl[`APT_CTRL_OPM] ||
				st_r.chmode[1:0] == 2'h3))
			st_nxt.ctrl[`APT_CTRL_EN] = 1'b0;
		if (upd)
			sts_set[`APT_STS_UPD] = 1'b1;

		// [RQ11] Break clears main output enable
		if (brk_now) begin
			st_nxt.ctrl[`APT_CTRL_MOE] = 1'b0;
			sts_set[`APT_STS_BRK]      = 1'b1;
		end
		// Events are kept apart from the old flags so that a clear
		// written in the same cycle cannot swallow them
		st_nxt.sts = st_r.sts | sts_set;

		// [RQ5] Dead-time restarts on each edge
		// Both lines of a pair idle for DTG cycles after a ref edge
		for (int i = 0; i < 3; i++) begin
			if (ref_nxt[i] != st_r.ref_o[i])
				st_nxt.dt[i] = st_r.dtg;
			else if (st_r.dt[i] != 8'h00)
				st_nxt.dt[i] = st_r.dt[i] - 8'h01;
		end

		// [RQ7] [RQ11] Forced inactive levels
		off = brk_now | frz | ~st_r.ctrl[`APT_CTRL_MOE];
		// [RQ6] Three pairs on six lines
		for (int i = 0; i < 3; i++) begin
			st_nxt.oc[i]  = st_r.pol[i] ^ (~off & st_r.ref_o[i] &
				(st_r.dt[i] == 8'h00));
			st_nxt.ocn[i] = st_r.pol[4+i] ^ (~off & ~st_r.ref_o[i] &
				(st_r.dt[i] == 8'h00) &
				(st_r.chmode[2*i +: 2] != 2'h0));
		end
		st_nxt.oc[3] = st_r.pol[3] ^ (~off & st_r.ref_o[3]);

		// APB: read data prepared in setup, writes land in access
		wr  = PSEL & PENABLE & PWRITE;
		// Unmapped or misaligned offsets answer an error and read zero
		hit = (a[1:0] == 2'b00) && (a <= `APT_OFS_CCR0 + 8'h0C);
		if (PSEL && !PENABLE) begin
			st_nxt.rdata = 32'h00000000;
			if (is_reg(a, `APT_OFS_CTRL))
				st_nxt.rdata = {16'h0000, st_r.ctrl};
			if (is_reg(a, `APT_OFS_PSC))
				st_nxt.rdata = {16'h0000, st_r.psc};
			if (is_reg(a, `APT_OFS_ARR))
				st_nxt.rdata = widen(st_r.arr);
			if (is_reg(a, `APT_OFS_CNT))
				st_nxt.rdata = widen(st_r.cnt);
			if (is_reg(a, `APT_OFS_DTG))
				st_nxt.rdata = {24'h000000, st_r.dtg};
			if (is_reg(a, `APT_OFS_CHMODE))
				st_nxt.rdata = {24'h000000, st_r.chmode};
			if (is_reg(a, `APT_OFS_POL))
				st_nxt.rdata = {25'h0000000, st_r.pol};
			if (is_reg(a, `APT_OFS_STS))
				st_nxt.rdata = {26'h0000000, st_r.sts};
			for (int i = 0; i < 4; i++)
				if (is_reg(a, `APT_OFS_CCR0 + 8'(4*i)))
					st_nxt.rdata = widen(st_r.ccr[i]);
		end
		if (wr) begin
			if (is_reg(a, `APT_OFS_CTRL))
				st_nxt.ctrl = PWDATA[15:0];
			if (is_reg(a, `APT_OFS_PSC))
				st_nxt.psc = PWDATA[15:0];
			if (is_reg(a, `APT_OFS_ARR))
				st_nxt.arr = PWDATA[CNT_W-1:0];
			if (is_reg(a, `APT_OFS_CNT))
				st_nxt.cnt = PWDATA[CNT_W-1:0];
			if (is_reg(a, `APT_OFS_DTG))
				st_nxt.dtg = PWDATA[7:0];
			if (is_reg(a, `APT_OFS_CHMODE))
				st_nxt.chmode = PWDATA[7:0];
			if (is_reg(a, `APT_OFS_POL))
				st_nxt.pol = PWDATA[6:0];
			// Write one to clear; a fresh event in the same cycle wins,
			// even when its flag was already set before the clear
			if (is_reg(a, `APT_OFS_STS))
				st_nxt.sts = (st_r.sts & ~PWDATA[5:0]) | sts_set;
			for (int i = 0; i < 4; i++)
				if (is_reg(a, `APT_OFS_CCR0 + 8'(4*i)))
					st_nxt.ccr[i] = PWDATA[CNT_W-1:0];
			// MOE stays low while a break is held
			if (brk_now)
				st_nxt.ctrl[`APT_CTRL_MOE] = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			st_r        <= '0;
			st_r.ctrl   <= `APT_CTRL_RST;
			st_r.psc    <= `APT_PSC_RST;
			st_r.arr    <= CNT_W'(`APT_ARR_RST);
			st_r.dtg    <= `APT_DTG_RST;
			st_r.pol    <= `APT_POL_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign PRDATA  = st_r.rdata;
	// Zero wait states: every access ends in its first access cycle
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~hit;
	assign TRG_OUT = st_r.trg;
	assign OC      = st_r.oc;
	assign OCN     = st_r.ocn;

endmodule : apt_timer

// ==== apt_defines.svh ====
// Register map, field positions and reset values of the
// advanced PWM timer. Assumes a 32-bit APB with byte addresses.
// Notes on behaviour
// [RQ1] 16-bit counter counts up, down or centre
// [RQ2] Prescaler divides by 1 to 65536
// [RQ3] Four channels: capture, compare, PWM, one-pulse; one-pulse mode stops the counter on channel 0 only
// [RQ4] PWM edge or centre aligned, 0-100% duty
// [RQ5] Complementary pairs with programmable dead-time
// [RQ6] Three phases on six output lines
// [RQ7] Debug halt freezes counter, disables outputs
// [RQ8] Trigger in and out between timers
// [RQ9] Comparator output is a break source
// [RQ10] Clock, fault, parity, ECC, supply breaks
// [RQ11] Break forces inactive levels within cycles
`ifndef APT_DEFINES_SVH
`define APT_DEFINES_SVH

`define APT_OFS_CTRL   8'h00
`define APT_OFS_PSC    8'h04
`define APT_OFS_ARR    8'h08
`define APT_OFS_CNT    8'h0C
`define APT_OFS_DTG    8'h10
`define APT_OFS_CHMODE 8'h14
`define APT_OFS_POL    8'h18
`define APT_OFS_STS    8'h1C
`define APT_OFS_CCR0   8'h20

`define APT_CTRL_EN     0
`define APT_CTRL_DOWN   1
`define APT_CTRL_CENTER 2
`define APT_CTRL_OPM    3
`define APT_CTRL_MOE    4
`define APT_CTRL_DBGFRZ 5
`define APT_CTRL_TRGRST 6
`define APT_CTRL_TRGGO  7
`define APT_CTRL_BRK_LO 8

`define APT_STS_UPD  4
`define APT_STS_BRK  5

`define APT_CTRL_RST 16'h0000
`define APT_ARR_RST  16'hFFFF
`define APT_PSC_RST  16'h0000
`define APT_DTG_RST  8'h00
`define APT_POL_RST  7'h00

`endif

// ==== apt_pkg.sv ====
// Types shared by the advanced PWM timer.
// Assumes nothing of its surroundings.
package apt_pkg;
	typedef enum logic [1:0] {
		APT_CAPTURE,
		APT_COMPARE,
		APT_PWM,
		APT_ONEPULSE
	} apt_chmode_e;
endpackage : apt_pkg

// ==== apt_chk.sv ====
// Bus, break, freeze and trigger assertions for the PWM timer.
// Assumes it is bound to apt_timer and sees only its ports.
`timescale 1ns/1ps

module apt_chk (
	input wire logic        REF_CLK,       // clock
	input wire logic        RSTN,          // reset, low
	input wire logic        PSEL,          // bus select
	input wire logic        PENABLE,       // access phase
	input wire logic        PWRITE,        // direction
	input wire logic [7:0]  PADDR,         // address
	input wire logic [31:0] PWDATA,        // write data
	input wire logic [31:0] PRDATA,        // read data
	input wire logic        PREADY,        // ready
	input wire logic        PSLVERR,       // error
	input wire logic        DBG_HALT,      // debug halt
	input wire logic        TRG_OUT,       // trigger out
	input wire logic        BRK_PIN,       // break pin
	input wire logic        BRK_COMP,      // comparator break
	input wire logic        BRK_CLKFAIL,   // clock failure
	input wire logic        BRK_HARDFAULT, // hard fault
	input wire logic        BRK_PARITY,    // parity error
	input wire logic        BRK_ECC,       // ECC error
	input wire logic        BRK_SUPPLY,    // supply detector
	input wire logic [3:0]  OC,            // outputs
	input wire logic [2:0]  OCN            // complements
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);

	logic [14:0] ctrl_r;
	logic [6:0]  pol_r;
	wire         wr  = PSEL && PENABLE && PWRITE && PREADY;
	wire  [6:0]  src = {BRK_SUPPLY, BRK_ECC, BRK_PARITY, BRK_HARDFAULT,
		BRK_CLKFAIL, BRK_COMP, BRK_PIN};
	wire         brk = |(src & ctrl_r[14:8]);
	wire         frz = DBG_HALT && ctrl_r[5];
	wire         bad = PADDR > 8'h2C || PADDR[1:0] != 2'h0;

	// Shadow of the control and polarity words, fed by bus writes
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			ctrl_r <= 15'h0;
			pol_r  <= 7'h0;
		end else begin
			if (wr && PADDR == 8'h00) ctrl_r <= PWDATA[14:0];
			if (wr && PADDR == 8'h18) pol_r <= PWDATA[6:0];
		end
	end

	property p_rdy; PSEL && PENABLE |-> PREADY; endproperty
	a_rdy: assert property (p_rdy) else $error("access without ready");
	property p_err; PSEL && PENABLE && bad |-> PSLVERR; endproperty
	a_err: assert property (p_err) else $error("no error on bad address");
	property p_ok; PSEL && PENABLE && !bad |-> !PSLVERR; endproperty
	a_ok: assert property (p_ok) else $error("error on mapped address");
	property p_rd0;
		PSEL && PENABLE && !PWRITE && PSLVERR |-> PRDATA == 32'h0;
	endproperty
	a_rd0: assert property (p_rd0) else $error("refused read not zero");
	property p_rst;
		$rose(RSTN) |-> OC == 4'h0 && OCN == 3'h0 && !TRG_OUT;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs live at reset");
	property p_brk; brk |=> OC == pol_r[3:0] && OCN == pol_r[6:4]; endproperty
	a_brk: assert property (p_brk) else $error("break not forced");
	property p_frz; frz |=> OC == pol_r[3:0] && OCN == pol_r[6:4]; endproperty
	a_frz: assert property (p_frz) else $error("halt not forced");
	// The counter may also be started by the trigger-start enable
	property p_trg; TRG_OUT |-> $past(ctrl_r[0] | ctrl_r[7]); endproperty
	a_trg: assert property (p_trg) else $error("trigger while idle");

	c_brk: cover property (brk);
	c_frz: cover property (frz);
	c_err: cover property (PSEL && PENABLE && PSLVERR);
	c_trg: cover property (TRG_OUT);
endmodule : apt_chk

bind apt_timer apt_chk u_chk (.*);

// ==== apt_switch.sv ====
// Power stage and sensor pins at the far side of the timer.
// Assumes one clock shared with the timer; outputs active high.
`timescale 1ns/1ps

module apt_switch (
	input  wire logic       clk,           // clock
	input  wire logic [3:0] oc,            // high-side drives
	input  wire logic [2:0] ocn,           // low-side drives
	input  wire logic [3:0] kick,          // sensor pulse request
	output logic      [3:0] ch_in = 4'h0,  // sensor lines
	output logic            shoot = 1'h0   // a leg was shorted
);
	always_ff @(posedge clk) begin
		ch_in <= kick;
		if ((oc[2:0] & ocn) != 3'h0) shoot <= 1'h1;
	end
endmodule : apt_switch

// ==== advanced_pwm_timer_tb.sv ====
// Self-checking bench for the PWM timer over APB.
// Assumes apt_defines.svh and the bound checker are compiled.
`timescale 1ns/1ps
`include "apt_defines.svh"

module advanced_pwm_timer_tb;
	logic        REF_CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0;
	logic        PWRITE = 0, DBG_HALT = 0, TRG_IN = 0;
	logic [7:0]  PADDR = 0;
	logic [31:0] PWDATA = 0, rv;
	logic [6:0]  brk = 0;
	logic [3:0]  kick = 0;
	logic        er;
	wire  [31:0] PRDATA;
	wire         PREADY, PSLVERR, TRG_OUT, shoot;
	wire  [3:0]  OC, CH_IN;
	wire  [2:0]  OCN;
	wire BRK_PIN = brk[0], BRK_COMP = brk[1], BRK_CLKFAIL = brk[2];
	wire BRK_HARDFAULT = brk[3], BRK_PARITY = brk[4];
	wire BRK_ECC = brk[5], BRK_SUPPLY = brk[6];
	int n_errors = 0, checks_done = 0, nt, no, nn;
	// Active clocks per 96-clock window: CCR0 ticks of ref per period,
	// less one dead-time cycle (DTG is 1) after each ref edge
	int eo[3] = '{0, 36, 96};
	int en[3] = '{96, 36, 0};
	int cc[3] = '{0, 2, 4};

	apt_timer DUT (.*);
	apt_switch u_sw (.clk(REF_CLK), .oc(OC), .ocn(OCN), .kick(kick),
		.ch_in(CH_IN), .shoot(shoot));

	initial forever #10 REF_CLK = ~REF_CLK;

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
		int i;
		@(posedge REF_CLK);
		PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= a; PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge REF_CLK);
			if (PREADY === 1'h1) break;
		end
		rv = PRDATA;
		er = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
		if (i == 20) begin
			n_errors++;
			conclude();
		end
	endtask : xfer

	// Counts pulses and active cycles over a window of n clocks
	task automatic watch(int n);
		nt = 0; no = 0; nn = 0;
		repeat (n) begin
			@(posedge REF_CLK);
			nt += (TRG_OUT === 1'h1);
			no += (OC[0] === 1'h1);
			nn += (OCN[0] === 1'h1);
		end
	endtask : watch

	initial begin
		repeat (20) @(posedge REF_CLK);
		RSTN <= 1;
		xfer(0, `APT_OFS_ARR, 0); chk("arr", rv, 32'hFFFF);
		xfer(0, `APT_OFS_CTRL, 0); chk("ctrl", rv, 32'h0);
		xfer(1, 8'h30, 32'h5); chk("err", er, 1'h1);
		xfer(0, 8'h30, 0); chk("gap", rv, 32'h0);
		$display("register map done");
		xfer(1, `APT_OFS_PSC, 32'h1);
		xfer(1, `APT_OFS_ARR, 32'h3);
		// Up, down, centre: period 8, 8 and 12 clocks
		foreach (cc[k]) begin
			xfer(1, `APT_OFS_CTRL, k == 2 ? 32'h5 : 32'h1 | k << 1);
			repeat (30) @(posedge REF_CLK);
			watch(96); chk("updates", nt, k == 2 ? 8 : 12);
		end
		$display("counting done");
		xfer(1, `APT_OFS_CHMODE, 32'h2);
		xfer(1, `APT_OFS_DTG, 32'h1);
		xfer(1, `APT_OFS_CTRL, 32'h11);
		foreach (cc[k]) begin
			xfer(1, `APT_OFS_CCR0, cc[k]);
			repeat (30) @(posedge REF_CLK);
			watch(96); chk("oc", no, eo[k]);
			chk("ocn", nn, en[k]);
		end
		chk("shoot", shoot, 1'h0);
		chk("idle", {OC[3:1], OCN[2:1]}, 5'h00);
		$display("pwm done");
		for (int k = 0; k < 7; k++) begin
			xfer(1, `APT_OFS_CTRL, 32'h11 | 32'h100 << k);
			repeat (4) @(posedge REF_CLK);
			chk("live", OC[0], 1'h1);
			brk <= 7'h1 << k;
			repeat (3) @(posedge REF_CLK);
			chk("brk", OC[0], 1'h0);
			xfer(0, `APT_OFS_STS, 0); chk("flag", rv[5], 1'h1);
			brk <= 7'h0;
			xfer(1, `APT_OFS_STS, 32'h20);
		end
		$display("break done");
		xfer(1, `APT_OFS_CTRL, 32'h31);
		DBG_HALT <= 1;
		repeat (3) @(posedge REF_CLK);
		chk("halt", OC[0], 1'h0);
		xfer(0, `APT_OFS_CNT, 0); nt = rv;
		xfer(0, `APT_OFS_CNT, 0); chk("frozen", rv, nt);
		DBG_HALT <= 0;
		xfer(1, `APT_OFS_CTRL, 32'h11);
		xfer(1, `APT_OFS_STS, 32'h3F);
		kick <= 4'h2;
		@(posedge REF_CLK);
		kick <= 4'h0;
		repeat (3) @(posedge REF_CLK);
		xfer(0, `APT_OFS_STS, 0); chk("capture", rv[1], 1'h1);
		xfer(1, `APT_OFS_CTRL, 32'h9);
		repeat (40) @(posedge REF_CLK);
		xfer(0, `APT_OFS_CTRL, 0); chk("onepulse", rv[0], 1'h0);
		xfer(1, `APT_OFS_CTRL, 32'h80);
		TRG_IN <= 1;
		repeat (2) @(posedge REF_CLK);
		TRG_IN <= 0;
		xfer(0, `APT_OFS_CTRL, 0); chk("trgstart", rv[0], 1'h1);
		xfer(1, `APT_OFS_CHMODE, 32'h1);
		xfer(1, `APT_OFS_CCR0, 32'h2);
		xfer(1, `APT_OFS_STS, 32'h3F);
		repeat (20) @(posedge REF_CLK);
		xfer(0, `APT_OFS_STS, 0); chk("match", rv[0], 1'h1);
		$display("modes done");
		conclude();
	end
endmodule : advanced_pwm_timer_tb
